// ==== rtl/fpd_pkg.sv ====
`default_nettype none
package fpd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DEEP_SLEEP  = 8'hB9;
  localparam logic [7:0] CMD_ULTRA_SLEEP = 8'h79;
  localparam logic [7:0] CMD_RESUME      = 8'hAB;
  localparam logic [7:0] CMD_RESET_ARM   = 8'h66;
  localparam logic [7:0] CMD_RESET_GO    = 8'h99;

  // The value is arbitrary.
  localparam logic [7:0] DEVICE_ID       = 8'h5A;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [2:0] ID_FIRST_BYTE   = 3'h4;
  localparam logic [2:0] BYTE_COUNT_SAT  = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS                = 10;
  localparam int DEEP_SLEEP_ENTRY_TIME_NS     = 3000;
  localparam int DEEP_SLEEP_EXIT_TIME_NS      = 8000;
  localparam int ULTRA_SLEEP_ENTRY_TIME_NS    = 3000;
  localparam int ULTRA_SLEEP_EXIT_TIME_NS     = 40000;
  localparam logic [11:0] DEEP_ENTRY_CYC  = 12'(DEEP_SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] DEEP_EXIT_CYC   = 12'(DEEP_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] ULTRA_ENTRY_CYC = 12'(ULTRA_SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] ULTRA_EXIT_CYC  = 12'(ULTRA_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [3:0]  SCLK_HALF_CYC   = 4'h4;
  localparam logic [3:0]  CS_GAP_CYC      = 4'h8;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_STANDBY, PWR_DEEP_IN, PWR_DEEP, PWR_DEEP_OUT,
    PWR_ULTRA_IN, PWR_ULTRA, PWR_ULTRA_OUT
  } fpd_pwr_t;

  typedef enum logic [1:0] {
    HST_IDLE, HST_LOW, HST_HIGH, HST_GAP
  } fpd_hst_t;

endpackage
`default_nettype wire

// ==== rtl/fpd_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fpd_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  modport dev  (input cs_n, input sclk, input si, output so, output so_oe);
  modport host (output cs_n, output sclk, output si, input so, input so_oe);
endinterface
`default_nettype wire

// ==== rtl/fpd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpd_sync #(
  parameter logic INIT = 1'b0
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic meta;
    logic hold;
  } fpd_sync_t;

  fpd_sync_t s_reg;
  fpd_sync_t s_next;

  always_comb
  begin
    s_next.meta = d;
    s_next.hold = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= {INIT, INIT};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.hold;

endmodule
`default_nettype wire

// ==== rtl/fpd_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpd_device #(
  parameter logic [11:0] DEEP_IN_CYC   = fpd_pkg::DEEP_ENTRY_CYC,
  parameter logic [11:0] DEEP_OUT_CYC  = fpd_pkg::DEEP_EXIT_CYC,
  parameter logic [11:0] ULTRA_IN_CYC  = fpd_pkg::ULTRA_ENTRY_CYC,
  parameter logic [11:0] ULTRA_OUT_CYC = fpd_pkg::ULTRA_EXIT_CYC,
  parameter logic [7:0]  ID_VALUE      = fpd_pkg::DEVICE_ID
)(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  fpd_if.dev        link,
  input  wire logic sleep_depth_select,
  input  wire logic operation_in_progress_flag,
  output logic      deep_sleep_state,
  output logic      ultra_sleep_state,
  output logic      power_busy,
  output logic      sram_reset,
  output logic      device_reset
);

  // ----------------------------------------------------------------
  // Link side, clocked by the serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] shift;
    logic [7:0] cmd;
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
    logic       tog;
    logic       so;
    logic       so_oe;
  } fpd_lnk_t;

  fpd_lnk_t   lnk_reg;
  fpd_lnk_t   lnk_next;
  logic       started;
  logic       frame_clr;
  logic       no_id_lnk;
  logic [2:0] base_bit;
  logic [2:0] base_byte;

  // The serial clock stops between frames, so the start of a frame is
  // marked by a flag that chip select clears without a clock edge.
  assign frame_clr = link.cs_n | ~rst_n;

  always_ff @(posedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      started <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
    end
  end

  always_comb
  begin
    lnk_next  = lnk_reg;
    base_bit  = started ? lnk_reg.bitcnt : 3'h0;
    base_byte = started ? lnk_reg.bytecnt : 3'h0;
    lnk_next.tog = started ? lnk_reg.tog : ~lnk_reg.tog;
    lnk_next.shift = {lnk_reg.shift[5:0], link.si};
    lnk_next.bitcnt = base_bit + 3'h1;
    lnk_next.bytecnt = base_byte;
    if (base_bit == 3'h7)
    begin
      if (base_byte == 3'h0)
      begin
        lnk_next.cmd = {lnk_reg.shift, link.si};
      end
      if (base_byte != fpd_pkg::BYTE_COUNT_SAT)
      begin
        lnk_next.bytecnt = base_byte + 3'h1;
      end
    end
    lnk_next.so    = 1'b0;
    lnk_next.so_oe = 1'b0;
    if ((lnk_next.bytecnt >= fpd_pkg::ID_FIRST_BYTE) &&
        (lnk_next.cmd == fpd_pkg::CMD_RESUME) && !no_id_lnk)
    begin
      lnk_next.so    = ID_VALUE[3'h7 - lnk_next.bitcnt];
      lnk_next.so_oe = 1'b1;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk_reg <= '0;
    end
    else
    begin
      lnk_reg <= lnk_next;
    end
  end

  // The output enable left over from an earlier readout stays in the
  // register until the first clock of the next frame, so it is masked
  // until that clock has been seen.
  assign link.so    = lnk_reg.so;
  assign link.so_oe = lnk_reg.so_oe & started & ~link.cs_n;

  // ----------------------------------------------------------------
  // Power control, clocked by the core clock except u_no_id_sync, which uses the serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    fpd_pkg::fpd_pwr_t pwr;
    logic [11:0]       timer;
    logic              cs_prev;
    logic              tog_seen;
    logic              armed;
    logic              deep;
    logic              ultra;
    logic              busy;
    logic              no_id;
    logic              sram_rst;
    logic              dev_rst;
  } fpd_core_t;

  fpd_core_t core_reg;
  fpd_core_t core_next;
  logic      cs_s;
  logic      frame_end;
  logic      new_frame;
  logic      aligned;
  logic      one_byte;
  logic      any_byte;
  logic      may_reset;

  fpd_sync #(.INIT(1'b1)) u_cs_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (link.cs_n),
    .q     (cs_s)
  );

  fpd_sync #(.INIT(1'b0)) u_no_id_sync (
    .clk   (link.sclk),
    .rst_n (rst_n),
    .d     (core_reg.no_id),
    .q     (no_id_lnk)
  );

  // Frame fields are read only once chip select has risen; the serial
  // clock is then still, so they hold steady until the next frame.
  // A frame without clocks leaves the toggle alone and is dropped.
  assign frame_end = cs_s & ~core_reg.cs_prev;
  assign new_frame = frame_end & (lnk_reg.tog != core_reg.tog_seen);
  assign aligned   = (lnk_reg.bitcnt == 3'h0);
  assign one_byte  = aligned & (lnk_reg.bytecnt == 3'h1);
  assign any_byte  = aligned & (lnk_reg.bytecnt != 3'h0);
  assign may_reset = (core_reg.pwr == fpd_pkg::PWR_STANDBY) ||
                     (core_reg.pwr == fpd_pkg::PWR_DEEP);

  always_comb
  begin
    core_next          = core_reg;
    core_next.cs_prev  = cs_s;
    core_next.sram_rst = 1'b0;
    core_next.dev_rst  = 1'b0;
    if (frame_end)
    begin
      core_next.tog_seen = lnk_reg.tog;
    end
    case (core_reg.pwr)
      fpd_pkg::PWR_STANDBY:
      begin
        if (new_frame && !operation_in_progress_flag)
        begin
          if (one_byte && (lnk_reg.cmd == fpd_pkg::CMD_DEEP_SLEEP))
          begin
            if (sleep_depth_select)
            begin
              core_next.pwr   = fpd_pkg::PWR_DEEP_IN;
              core_next.timer = DEEP_IN_CYC - 12'h001;
            end
            else
            begin
              core_next.pwr   = fpd_pkg::PWR_ULTRA_IN;
              core_next.timer = ULTRA_IN_CYC - 12'h001;
            end
          end
          else if (any_byte && (lnk_reg.cmd == fpd_pkg::CMD_ULTRA_SLEEP))
          begin
            core_next.pwr   = fpd_pkg::PWR_ULTRA_IN;
            core_next.timer = ULTRA_IN_CYC - 12'h001;
          end
        end
      end
      fpd_pkg::PWR_DEEP:
      begin
        // One or two trailing bytes are an unfinished identifier read.
        if (new_frame && aligned && (lnk_reg.cmd == fpd_pkg::CMD_RESUME) &&
            ((lnk_reg.bytecnt == 3'h1) ||
             (lnk_reg.bytecnt >= fpd_pkg::ID_FIRST_BYTE)))
        begin
          core_next.pwr   = fpd_pkg::PWR_DEEP_OUT;
          core_next.timer = DEEP_OUT_CYC - 12'h001;
        end
      end
      fpd_pkg::PWR_ULTRA:
      begin
        if (new_frame && any_byte && (lnk_reg.cmd == fpd_pkg::CMD_RESUME))
        begin
          core_next.pwr      = fpd_pkg::PWR_ULTRA_OUT;
          core_next.timer    = ULTRA_OUT_CYC - 12'h001;
          core_next.sram_rst = 1'b1;
        end
      end
      fpd_pkg::PWR_DEEP_IN, fpd_pkg::PWR_DEEP_OUT,
      fpd_pkg::PWR_ULTRA_IN, fpd_pkg::PWR_ULTRA_OUT:
      begin
        if (core_reg.timer == 12'h000)
        begin
          case (core_reg.pwr)
            fpd_pkg::PWR_DEEP_IN:  core_next.pwr = fpd_pkg::PWR_DEEP;
            fpd_pkg::PWR_ULTRA_IN: core_next.pwr = fpd_pkg::PWR_ULTRA;
            default:               core_next.pwr = fpd_pkg::PWR_STANDBY;
          endcase
        end
        else
        begin
          core_next.timer = core_reg.timer - 12'h001;
        end
      end
      default:
      begin
        core_next.pwr = fpd_pkg::PWR_STANDBY;
      end
    endcase
    if (new_frame)
    begin
      core_next.armed = may_reset && one_byte &&
                        (lnk_reg.cmd == fpd_pkg::CMD_RESET_ARM);
      if (may_reset && one_byte && core_reg.armed &&
          (lnk_reg.cmd == fpd_pkg::CMD_RESET_GO))
      begin
        core_next.dev_rst = 1'b1;
        core_next.pwr     = fpd_pkg::PWR_STANDBY;
      end
    end
    core_next.deep  = (core_next.pwr == fpd_pkg::PWR_DEEP);
    core_next.ultra = (core_next.pwr == fpd_pkg::PWR_ULTRA);
    core_next.busy  = (core_next.pwr == fpd_pkg::PWR_DEEP_IN) ||
                      (core_next.pwr == fpd_pkg::PWR_DEEP_OUT) ||
                      (core_next.pwr == fpd_pkg::PWR_ULTRA_IN) ||
                      (core_next.pwr == fpd_pkg::PWR_ULTRA_OUT);
    core_next.no_id = core_next.ultra ||
                      (core_next.pwr == fpd_pkg::PWR_ULTRA_IN) ||
                      (core_next.pwr == fpd_pkg::PWR_ULTRA_OUT);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reg         <= '0;
      core_reg.pwr     <= fpd_pkg::PWR_STANDBY;
      core_reg.cs_prev <= 1'b1;
    end
    else if (ce)
    begin
      core_reg <= core_next;
    end
  end

  assign deep_sleep_state  = core_reg.deep;
  assign ultra_sleep_state = core_reg.ultra;
  assign power_busy        = core_reg.busy;
  assign sram_reset        = core_reg.sram_rst;
  assign device_reset      = core_reg.dev_rst;

endmodule
`default_nettype wire

// ==== rtl/fpd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpd_host (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  fpd_if.host             link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [7:0] cmd_byte,
  input  wire logic [7:0] cmd_bits,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data
);

  typedef struct packed {
    fpd_pkg::fpd_hst_t st;
    logic [3:0]        cnt;
    logic [7:0]        left;
    logic [7:0]        tx;
    logic [7:0]        rx;
    logic              cs_n;
    logic              sclk;
    logic              rsp_valid;
    logic [7:0]        rsp_data;
  } fpd_hst_reg_t;

  fpd_hst_reg_t h_reg;
  fpd_hst_reg_t h_next;
  logic         so_s;

  fpd_sync #(.INIT(1'b0)) u_so_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (link.so),
    .q     (so_s)
  );

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Each serial clock half lasts several core cycles so that the
  // synchronised serial output has settled before it is sampled.
  always_comb
  begin
    h_next           = h_reg;
    h_next.rsp_valid = 1'b0;
    case (h_reg.st)
      fpd_pkg::HST_IDLE:
      begin
        if (cmd_valid && (cmd_bits != 8'h00))
        begin
          h_next.st   = fpd_pkg::HST_LOW;
          h_next.cnt  = fpd_pkg::SCLK_HALF_CYC - 4'h1;
          h_next.left = cmd_bits;
          h_next.tx   = cmd_byte;
          h_next.cs_n = 1'b0;
        end
      end
      fpd_pkg::HST_LOW:
      begin
        if (h_reg.cnt == 4'h0)
        begin
          h_next.rx   = {h_reg.rx[6:0], so_s};
          h_next.sclk = 1'b1;
          h_next.st   = fpd_pkg::HST_HIGH;
          h_next.cnt  = fpd_pkg::SCLK_HALF_CYC - 4'h1;
        end
        else
        begin
          h_next.cnt = h_reg.cnt - 4'h1;
        end
      end
      fpd_pkg::HST_HIGH:
      begin
        if (h_reg.cnt == 4'h0)
        begin
          h_next.sclk = 1'b0;
          h_next.left = h_reg.left - 8'h01;
          h_next.tx   = {h_reg.tx[6:0], 1'b0};
          h_next.cnt  = fpd_pkg::SCLK_HALF_CYC - 4'h1;
          if (h_reg.left == 8'h01)
          begin
            // Chip select rises only after the last clock.
            h_next.cs_n      = 1'b1;
            h_next.st        = fpd_pkg::HST_GAP;
            h_next.cnt       = fpd_pkg::CS_GAP_CYC - 4'h1;
            h_next.rsp_valid = 1'b1;
            h_next.rsp_data  = h_next.rx;
          end
          else
          begin
            h_next.st = fpd_pkg::HST_LOW;
          end
        end
        else
        begin
          h_next.cnt = h_reg.cnt - 4'h1;
        end
      end
      fpd_pkg::HST_GAP:
      begin
        if (h_reg.cnt == 4'h0)
        begin
          h_next.st = fpd_pkg::HST_IDLE;
        end
        else
        begin
          h_next.cnt = h_reg.cnt - 4'h1;
        end
      end
      default:
      begin
        h_next.st = fpd_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_reg      <= '0;
      h_reg.st   <= fpd_pkg::HST_IDLE;
      h_reg.cs_n <= 1'b1;
    end
    else if (ce)
    begin
      h_reg <= h_next;
    end
  end

  assign cmd_ready = (h_reg.st == fpd_pkg::HST_IDLE);
  assign rsp_valid = h_reg.rsp_valid;
  assign rsp_data  = h_reg.rsp_data;
  assign link.cs_n = h_reg.cs_n;
  assign link.sclk = h_reg.sclk;
  assign link.si   = h_reg.tx[7];

endmodule
`default_nettype wire

// ==== bench/fpd_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpd_link_sva #(
  parameter logic [7:0] ID_VALUE = fpd_pkg::DEVICE_ID
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  // ------------------------------------------------------------
  // Link edge count
  // ------------------------------------------------------------
  // Chip select clears it directly, so a short gap cannot leak counts.
  logic [7:0] edge_cnt;
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
      edge_cnt <= 8'h00;
    else if (cs_n)
      edge_cnt <= 8'h00;
    else
      edge_cnt <= edge_cnt + 8'h01;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  property p_oe_in_frame;
    @(posedge core_clk) disable iff (!rst_n) (cs_n || $past(cs_n)) |-> !so_oe;
  endproperty
  property p_sclk_idle;
    @(posedge core_clk) disable iff (!rst_n) cs_n |-> !sclk;
  endproperty
  property p_si_hold;
    @(posedge core_clk) disable iff (!rst_n) (sclk && $past(sclk)) |-> $stable(si);
  endproperty
  property p_high_half;
    @(posedge core_clk) disable iff (!rst_n) $rose(sclk) |-> s_high_half;
  endproperty
  property p_gap;
    @(posedge core_clk) disable iff (!rst_n) $rose(cs_n) |-> cs_n [*8];
  endproperty
  property p_id_bits;
    @(posedge sclk) disable iff (!rst_n)
      so_oe |-> (edge_cnt >= 8'h20) && (so == ID_VALUE[~edge_cnt[2:0]]);
  endproperty
  property p_id_repeat;
    @(posedge sclk) disable iff (!rst_n) (so_oe && $past(so_oe, 8)) |-> so == $past(so, 8);
  endproperty
  property p_oe_holds;
    @(posedge sclk) disable iff (!rst_n) (edge_cnt > 8'h20 && $past(so_oe)) |-> so_oe;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame)
    else $error("serial out driven outside a frame");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock not idle low between frames");
  a_si_hold: assert property (p_si_hold)
    else $error("serial in changed while serial clock high");
  a_high_half: assert property (p_high_half)
    else $error("serial clock high phase has wrong length");
  a_gap: assert property (p_gap)
    else $error("chip select gap too short");
  a_id_bits: assert property (p_id_bits)
    else $error("identifier bit wrong or early");
  a_id_repeat: assert property (p_id_repeat)
    else $error("identifier not repeating");
  a_oe_holds: assert property (p_oe_holds)
    else $error("identifier output stopped inside frame");
endmodule
`default_nettype wire

// ==== bench/flash_power_down_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_power_down_control_test;
  // ------------------------------------------------------------
  // Bench setup
  // ------------------------------------------------------------
  // Short delays keep the run brief; every expected busy length uses them.
  localparam logic [11:0] D_IN  = 12'h005;
  localparam logic [11:0] D_OUT = 12'h006;
  localparam logic [11:0] U_IN  = 12'h007;
  localparam logic [11:0] U_OUT = 12'h009;
  localparam logic [7:0]  ID    = fpd_pkg::DEVICE_ID;
  localparam logic [7:0]  SLP   = fpd_pkg::CMD_DEEP_SLEEP;
  localparam logic [7:0]  ULT   = fpd_pkg::CMD_ULTRA_SLEEP;
  localparam logic [7:0]  RES   = fpd_pkg::CMD_RESUME;
  localparam logic [7:0]  ARM   = fpd_pkg::CMD_RESET_ARM;
  localparam logic [7:0]  GO    = fpd_pkg::CMD_RESET_GO;
  logic       core_clk;
  logic       rst_n;
  logic       ce;
  logic       depth;
  logic       op_busy;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_byte;
  logic [7:0] cmd_bits;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] last_rsp;
  logic       deep_q;
  logic       ultra_q;
  logic       power_busy;
  logic       sram_reset;
  logic       device_reset;
  int err_total = 0, tests_run = 0, run_len = 0, last_len = 0;
  int n_busy = 0, n_sram = 0, n_drst = 0, n_oe = 0;
  fpd_if fpd_if_i ();
  fpd_device #(.DEEP_IN_CYC(D_IN), .DEEP_OUT_CYC(D_OUT), .ULTRA_IN_CYC(U_IN),
    .ULTRA_OUT_CYC(U_OUT), .ID_VALUE(ID)) fpd_device_i (.core_clk(core_clk),
    .rst_n(rst_n), .ce(ce), .link(fpd_if_i.dev), .sleep_depth_select(depth),
    .operation_in_progress_flag(op_busy), .deep_sleep_state(deep_q),
    .ultra_sleep_state(ultra_q), .power_busy(power_busy), .sram_reset(sram_reset),
    .device_reset(device_reset));
  fpd_host fpd_host_i (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .link(fpd_if_i.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_byte(cmd_byte),
    .cmd_bits(cmd_bits), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fpd_link_sva #(.ID_VALUE(ID)) fpd_link_sva_i (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n(fpd_if_i.cs_n), .sclk(fpd_if_i.sclk), .si(fpd_if_i.si), .so(fpd_if_i.so),
    .so_oe(fpd_if_i.so_oe));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Counts pulses and the length of each busy stretch.
  always @(posedge core_clk)
  begin
    if (power_busy === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      n_busy++;
      run_len = 0;
    end
    if (sram_reset === 1'b1)
      n_sram++;
    if (device_reset === 1'b1)
      n_drst++;
    if (fpd_if_i.so_oe === 1'b1)
      n_oe++;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d bad", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expire;
    chk_cnt(0, 1);
    print_verdict();
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] n);
    int k;
    k = 0;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte = b;
    cmd_bits = n;
    do
    begin
      @(posedge core_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 200);
    #1;
    cmd_valid = 1'b0;
    if (k >= 200)
      expire();
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 3000);
    if (k >= 3000)
      expire();
    #1;
    last_rsp = rsp_data;
  endtask
  // A zero length means no busy stretch may follow the frame.
  task automatic step(input logic [7:0] b, input logic [7:0] n, input logic [1:0] st,
                      input logic [11:0] len);
    int b0;
    int k;
    b0 = n_busy;
    k = 0;
    send(b, n);
    repeat (5) @(posedge core_clk);
    while (power_busy !== 1'b0 && k < 5000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 5000)
      expire();
    @(posedge core_clk);
    #1;
    chk_val({6'h00, deep_q, ultra_q}, {6'h00, st});
    chk_cnt(n_busy - b0, (len != 12'h000) ? 1 : 0);
    if (len != 12'h000)
      chk_cnt(last_len, int'(len));
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_deep;
    step(SLP, 8'h07, 2'h0, 12'h000);
    step(SLP, 8'h08, 2'h2, D_IN);
    step(8'h05, 8'h08, 2'h2, 12'h000);
    step(ULT, 8'h08, 2'h2, 12'h000);
    step(RES, 8'h07, 2'h2, 12'h000);
    step(RES, 8'h08, 2'h0, D_OUT);
    $display("test deep done");
  endtask
  task automatic t_ultra;
    int r;
    int s;
    step(ULT, 8'h0C, 2'h0, 12'h000);
    step(ULT, 8'h10, 2'h1, U_IN);
    step(SLP, 8'h08, 2'h1, 12'h000);
    r = n_drst;
    step(ARM, 8'h08, 2'h1, 12'h000);
    step(GO, 8'h08, 2'h1, 12'h000);
    chk_cnt(n_drst - r, 0);
    s = n_sram;
    step(RES, 8'h08, 2'h0, U_OUT);
    chk_cnt(n_sram - s, 1);
    depth = 1'b0;
    step(SLP, 8'h08, 2'h1, U_IN);
    s = n_sram;
    r = n_oe;
    step(RES, 8'h28, 2'h0, U_OUT);
    chk_cnt(n_oe - r, 0);
    chk_cnt(n_sram - s, 1);
    depth = 1'b1;
    $display("test ultra done");
  endtask
  task automatic t_id;
    step(RES, 8'h28, 2'h0, 12'h000);
    chk_val(last_rsp, ID);
    step(RES, 8'h30, 2'h0, 12'h000);
    chk_val(last_rsp, ID);
    step(SLP, 8'h08, 2'h2, D_IN);
    step(RES, 8'h28, 2'h0, D_OUT);
    chk_val(last_rsp, ID);
    $display("test id done");
  endtask
  task automatic t_op;
    op_busy = 1'b1;
    step(SLP, 8'h08, 2'h0, 12'h000);
    step(ULT, 8'h08, 2'h0, 12'h000);
    op_busy = 1'b0;
    step(SLP, 8'h08, 2'h2, D_IN);
    step(RES, 8'h08, 2'h0, D_OUT);
    $display("test busy op done");
  endtask
  task automatic t_reset;
    int r;
    r = n_drst;
    step(ARM, 8'h08, 2'h0, 12'h000);
    step(GO, 8'h08, 2'h0, 12'h000);
    chk_cnt(n_drst - r, 1);
    step(ARM, 8'h08, 2'h0, 12'h000);
    step(8'h05, 8'h08, 2'h0, 12'h000);
    step(GO, 8'h08, 2'h0, 12'h000);
    chk_cnt(n_drst - r, 1);
    step(SLP, 8'h08, 2'h2, D_IN);
    step(ARM, 8'h08, 2'h2, 12'h000);
    step(GO, 8'h08, 2'h0, 12'h000);
    chk_cnt(n_drst - r, 2);
    $display("test reset done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    depth = 1'b1;
    op_busy = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_bits = 8'h00;
    last_rsp = 8'h00;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    t_deep();
    t_ultra();
    t_id();
    t_op();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
